// ===== drive_front.sv
// Run-command decode and main frequency source selection.
// Assumes raw field terminals, analog inputs already digitised as
// signed 0.01 % values, and an Avalon-MM master on mclk.
`timescale 1ns/1ps
`default_nettype none
module drive_front (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [5:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire drive_front_pkg::terminals_s terminals,
  input  wire drive_front_pkg::override_s  overrides,
  input  wire logic signed [15:0]          analog_in_one,
  input  wire logic signed [15:0]          analog_in_two,
  input  wire logic [15:0]                 preset_freq,
  output var  drive_front_pkg::run_cmd_s   run_cmd,
  output logic signed [16:0]               main_ref
);

  // Two-stage synchronisers for every terminal
  drive_front_pkg::terminals_s sync_a;
  drive_front_pkg::terminals_s sync_b;
  drive_front_pkg::terminals_s sync_prev;
  drive_front_pkg::override_s  ovr_a;
  drive_front_pkg::override_s  ovr_b;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_prev <= '0;
      ovr_a     <= '0;
      ovr_b     <= '0;
    end else begin
      sync_a    <= terminals;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
      ovr_a     <= overrides;
      ovr_b     <= ovr_a;
    end
  end

  // Edges come only from the second stage, so each edge fires once
  wire run_rise = sync_b.run & ~sync_prev.run;
  wire dir_rise = sync_b.direction & ~sync_prev.direction;
  wire cw_step  = sync_b.pot_cw & ~sync_prev.pot_cw;
  wire ccw_step = sync_b.pot_ccw & ~sync_prev.pot_ccw;
  wire enter_p  = sync_b.pot_enter & ~sync_prev.pot_enter;
  wire escape_p = sync_b.pot_escape & ~sync_prev.pot_escape;

  // Configuration registers
  logic [1:0]  term_mode_reg;
  logic [3:0]  main_source_select;
  logic [15:0] digital_freq_setpoint;
  logic [15:0] max_freq_limit;
  logic [2:0]  link_cfg;
  logic [15:0] follower_scale_coef;
  logic signed [15:0] comm_follow;
  logic signed [15:0] comm_percent;
  logic [15:0] comm_direct;

  drive_front_pkg::term_mode_e terminal_control_mode_sel;
  assign terminal_control_mode_sel =
      drive_front_pkg::term_mode_e'(term_mode_reg);

  wire reverse_disabled = link_cfg[drive_front_pkg::REV_DIS_BIT];
  wire link_mode_sel    = link_cfg[drive_front_pkg::LINK_MODE_BIT];
  wire link_role_sel    = link_cfg[drive_front_pkg::LINK_ROLE_BIT];

  // Run decode state
  logic run_state;
  logic rev_state;
  logic restart_lock;
  logic next_run;
  logic next_rev;
  logic next_lock;

  wire two_line = (terminal_control_mode_sel ==
                   drive_front_pkg::TM_TWO_RUN_DIR) |
                  (terminal_control_mode_sel ==
                   drive_front_pkg::TM_TWO_FWD_REV);
  wire dir_eff  = sync_b.direction & ~(two_line & reverse_disabled);
  wire stop_open = ~sync_b.stop_nc;

  // Run command decode per terminal mode
  always_comb begin
    next_run  = run_state;
    next_rev  = rev_state;
    next_lock = restart_lock;
    unique case (terminal_control_mode_sel)
      drive_front_pkg::TM_TWO_RUN_DIR: begin
        if (!sync_b.run) begin
          next_lock = 1'b0;
        end else if (sync_b.ext_stop) begin
          next_lock = 1'b1;
        end
        next_run = sync_b.run & ~next_lock;
        next_rev = dir_eff;
      end
      drive_front_pkg::TM_TWO_FWD_REV: begin
        if (!sync_b.run && !dir_eff) begin
          next_lock = 1'b0;
        end else if (sync_b.ext_stop) begin
          next_lock = 1'b1;
        end
        // Both active together means stop
        next_run = (sync_b.run ^ dir_eff) & ~next_lock;
        next_rev = dir_eff & ~sync_b.run;
      end
      drive_front_pkg::TM_THREE_FR: begin
        next_lock = 1'b0;
        if (stop_open || sync_b.ext_stop) begin
          next_run = 1'b0;
        end else if (run_rise) begin
          next_run = 1'b1;
          next_rev = 1'b0;
        end else if (dir_rise) begin
          next_run = 1'b1;
          next_rev = 1'b1;
        end
      end
      drive_front_pkg::TM_THREE_RUN: begin
        next_lock = 1'b0;
        if (stop_open || sync_b.ext_stop) begin
          next_run = 1'b0;
        end else if (run_rise) begin
          next_run = 1'b1;
        end
        next_rev = sync_b.direction;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_state    <= 1'b0;
      rev_state    <= 1'b0;
      restart_lock <= 1'b0;
    end else begin
      run_state    <= next_run;
      rev_state    <= next_rev;
      restart_lock <= next_lock;
    end
  end

  assign run_cmd.run     = run_state;
  assign run_cmd.reverse = rev_state;

  // Pulse input measurement
  logic [15:0] pulse_percent;

  pulse_freq_meter u_meter (
    .mclk          (mclk),
    .rst           (rst),
    .pulse_sync    (sync_b.pulse),
    .pulse_percent (pulse_percent)
  );

  // Potentiometer: working copy edited, committed copy kept.
  // The committed copy stands in for non-volatile storage; persistence
  // over power loss is the job of whatever saves and reloads it.
  logic [15:0] pot_committed;
  logic [15:0] pot_work;
  logic        pot_editing;

  wire [15:0] pot_up   = (pot_work > max_freq_limit - drive_front_pkg::POT_STEP)
                         ? max_freq_limit
                         : pot_work + drive_front_pkg::POT_STEP;
  wire [15:0] pot_down = (pot_work < drive_front_pkg::POT_STEP)
                         ? 16'h0000 : pot_work - drive_front_pkg::POT_STEP;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pot_committed <= drive_front_pkg::RST_POT_VALUE;
      pot_work      <= drive_front_pkg::RST_POT_VALUE;
      pot_editing   <= 1'b0;
    end else if (escape_p) begin
      pot_work    <= pot_committed;
      pot_editing <= 1'b0;
    end else if (enter_p) begin
      pot_committed <= pot_work;
      pot_editing   <= 1'b0;
    end else if (cw_step && !ccw_step) begin
      pot_work    <= pot_up;
      pot_editing <= 1'b1;
    end else if (ccw_step && !cw_step) begin
      pot_work    <= pot_down;
      pot_editing <= 1'b1;
    end
  end

  // Override priority picks the effective source
  wire [3:0] eff_source =
      (|ovr_b.preset)      ? drive_front_pkg::SRC_PRESET  :
      ovr_b.force_digital  ? drive_front_pkg::SRC_DIGITAL :
      ovr_b.force_ain_one  ? drive_front_pkg::SRC_AIN_ONE :
      ovr_b.force_ain_two  ? drive_front_pkg::SRC_AIN_TWO :
      ovr_b.force_comm     ? drive_front_pkg::SRC_COMM_PCT :
      main_source_select;

  // Percent scaling: value in 0.01 % times max over 100.00 %
  function automatic logic signed [16:0] scale_pct(
      input logic signed [15:0] pct, input logic [15:0] max_f);
    logic signed [33:0] prod;
    prod = 34'(pct) * $signed({18'h00000, max_f});
    scale_pct = 17'(prod / $signed(34'(drive_front_pkg::PCT_FULL)));
  endfunction

  wire signed [33:0] follow_a = 34'(scale_pct(comm_follow, max_freq_limit));
  wire signed [33:0] follow_b =
      (follow_a * $signed({18'h00000, follower_scale_coef})) /
      $signed(34'(drive_front_pkg::PCT_FULL));
  wire is_follower = link_mode_sel & ~link_role_sel;
  wire [15:0] direct_clamped = (comm_direct > max_freq_limit) ?
                               max_freq_limit : comm_direct;
  wire [15:0] preset_clamped = (preset_freq > max_freq_limit) ?
                               max_freq_limit : preset_freq;

  logic signed [16:0] next_ref;

  // Reference per source
  always_comb begin
    next_ref = main_ref;
    unique case (eff_source)
      drive_front_pkg::SRC_DIGITAL:
        next_ref = $signed({1'b0, digital_freq_setpoint});
      drive_front_pkg::SRC_AIN_ONE:
        next_ref = scale_pct(analog_in_one, max_freq_limit);
      drive_front_pkg::SRC_AIN_TWO:
        next_ref = scale_pct(analog_in_two, max_freq_limit);
      drive_front_pkg::SRC_PULSE:
        next_ref = scale_pct(pulse_percent, max_freq_limit);
      drive_front_pkg::SRC_COMM_PCT:
        next_ref = is_follower ? 17'(follow_b) :
                   scale_pct(comm_percent, max_freq_limit);
      drive_front_pkg::SRC_COMM_DIR:
        next_ref = is_follower ? 17'(follow_b) :
                   $signed({1'b0, direct_clamped});
      drive_front_pkg::SRC_POT:
        next_ref = $signed({1'b0, pot_work});
      drive_front_pkg::SRC_PRESET:
        next_ref = $signed({1'b0, preset_clamped});
      default: next_ref = main_ref;  // Reserved codes hold the last value
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      main_ref <= 17'sh00000;
    end else begin
      main_ref <= next_ref;
    end
  end

  // Avalon slave: one wait cycle, answer at the second edge
  logic ack;
  wire  req    = avs_read | avs_write;
  wire  wr_hit = avs_write & ack;
  wire  be_lo  = avs_byteenable[0];
  wire  be_hi  = avs_byteenable[1];
  assign avs_waitrequest = req & ~ack;

  function automatic logic [15:0] merge(input logic [15:0] old_v,
      input logic [31:0] wd, input logic lo, input logic hi);
    merge = {hi ? wd[15:8] : old_v[15:8], lo ? wd[7:0] : old_v[7:0]};
  endfunction

  wire [31:0] status_word = {28'h0000000, pot_editing, restart_lock,
                             rev_state, run_state};

  logic [31:0] next_rdata;
  always_comb begin
    unique case (avs_address)
      drive_front_pkg::OFF_TERM_MODE:   next_rdata = {30'h0, term_mode_reg};
      drive_front_pkg::OFF_MAIN_SRC:    next_rdata = {28'h0, main_source_select};
      drive_front_pkg::OFF_DIGITAL_SET: next_rdata = {16'h0, digital_freq_setpoint};
      drive_front_pkg::OFF_MAX_FREQ:    next_rdata = {16'h0, max_freq_limit};
      drive_front_pkg::OFF_LINK_CFG:    next_rdata = {29'h0, link_cfg};
      drive_front_pkg::OFF_FOLLOW_COEF: next_rdata = {16'h0, follower_scale_coef};
      drive_front_pkg::OFF_COMM_FOLLOW: next_rdata = {16'h0, comm_follow};
      drive_front_pkg::OFF_COMM_PERCENT: next_rdata = {16'h0, comm_percent};
      drive_front_pkg::OFF_COMM_DIRECT: next_rdata = {16'h0, comm_direct};
      drive_front_pkg::OFF_STATUS:      next_rdata = status_word;
      drive_front_pkg::OFF_MAIN_REF:    next_rdata = 32'(main_ref);
      drive_front_pkg::OFF_POT_VIEW:    next_rdata = {16'h0, pot_committed};
      default:                          next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack          <= req & ~ack;
      if (avs_read && !ack) begin
        avs_readdata <= next_rdata;
      end
    end
  end

  // Register writes, taken at the edge where waitrequest is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      term_mode_reg         <= drive_front_pkg::RST_TERM_MODE;
      main_source_select    <= drive_front_pkg::RST_MAIN_SRC;
      digital_freq_setpoint <= drive_front_pkg::RST_DIGITAL_SET;
      max_freq_limit        <= drive_front_pkg::RST_MAX_FREQ;
      link_cfg              <= 3'h0;
      follower_scale_coef   <= drive_front_pkg::RST_FOLLOW_COEF;
      comm_follow           <= 16'sh0000;
      comm_percent          <= 16'sh0000;
      comm_direct           <= 16'h0000;
    end else if (wr_hit) begin
      unique case (avs_address)
        drive_front_pkg::OFF_TERM_MODE:
          if (be_lo) term_mode_reg <= avs_writedata[1:0];
        drive_front_pkg::OFF_MAIN_SRC:
          if (be_lo) main_source_select <= avs_writedata[3:0];
        drive_front_pkg::OFF_DIGITAL_SET:
          digital_freq_setpoint <= merge(digital_freq_setpoint,
                                         avs_writedata, be_lo, be_hi);
        drive_front_pkg::OFF_MAX_FREQ:
          max_freq_limit <= merge(max_freq_limit, avs_writedata, be_lo, be_hi);
        drive_front_pkg::OFF_LINK_CFG:
          if (be_lo) link_cfg <= avs_writedata[2:0];
        drive_front_pkg::OFF_FOLLOW_COEF:
          follower_scale_coef <= merge(follower_scale_coef, avs_writedata,
                                       be_lo, be_hi);
        drive_front_pkg::OFF_COMM_FOLLOW:
          comm_follow <= merge(comm_follow, avs_writedata, be_lo, be_hi);
        drive_front_pkg::OFF_COMM_PERCENT:
          comm_percent <= merge(comm_percent, avs_writedata, be_lo, be_hi);
        drive_front_pkg::OFF_COMM_DIRECT:
          comm_direct <= merge(comm_direct, avs_writedata, be_lo, be_hi);
        default: ;  // Read-only and unmapped writes are dropped
      endcase
    end
  end

endmodule // drive_front
`default_nettype wire

// ===== drive_front_checker_asserts.sv
// Port checker for the drive front end.
// Assumes one mclk domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module drive_front_checker (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic [5:0]                  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire drive_front_pkg::terminals_s terminals,
  input wire drive_front_pkg::run_cmd_s   run_cmd,
  input wire logic signed [16:0]          main_ref
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Every request is stretched by exactly one cycle
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait");
  property p_wait_once;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("long wait");
  property p_wait_idle;
    avs_waitrequest |-> avs_read || avs_write;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("idle wait");

  // Read data: unmapped reads zero, narrow source field, held between reads
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > 6'h30
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_src_width;
    avs_read && !avs_waitrequest && avs_address == 6'h04
      |-> avs_readdata[31:4] == 28'h0;
  endproperty
  a_src_width: assert property (p_src_width) else $error("src width");
  property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");

  // Outputs come out of reset idle; a held stop always wins
  property p_reset_out;
    $fell(rst) |-> run_cmd == 2'h0 && main_ref == 17'h0;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset out");
  property p_estop;
    terminals.ext_stop [*5] |-> !run_cmd.run;
  endproperty
  a_estop: assert property (p_estop) else $error("stop ignored");
endmodule // drive_front_checker

bind drive_front drive_front_checker i_drive_front_checker (
  .mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .terminals(terminals), .run_cmd(run_cmd), .main_ref(main_ref));
`default_nettype wire

// ===== drive_front_pkg.sv
// Package for the drive front end: register map, field layouts, reset
// values, mode encodings and shared structs.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register slave.
`default_nettype none
package drive_front_pkg;

  // Register byte offsets
  localparam logic [5:0] OFF_TERM_MODE    = 6'h00;
  localparam logic [5:0] OFF_MAIN_SRC     = 6'h04;
  localparam logic [5:0] OFF_DIGITAL_SET  = 6'h08;
  localparam logic [5:0] OFF_MAX_FREQ     = 6'h0C;
  localparam logic [5:0] OFF_LINK_CFG     = 6'h10;
  localparam logic [5:0] OFF_FOLLOW_COEF  = 6'h14;
  localparam logic [5:0] OFF_COMM_FOLLOW  = 6'h18;
  localparam logic [5:0] OFF_COMM_PERCENT = 6'h1C;
  localparam logic [5:0] OFF_COMM_DIRECT  = 6'h20;
  localparam logic [5:0] OFF_PRESET_FREQ  = 6'h24;
  localparam logic [5:0] OFF_STATUS       = 6'h28;
  localparam logic [5:0] OFF_MAIN_REF     = 6'h2C;
  localparam logic [5:0] OFF_POT_VIEW     = 6'h30;

  // Field positions
  localparam int LINK_MODE_BIT  = 0;
  localparam int LINK_ROLE_BIT  = 1;
  localparam int REV_DIS_BIT    = 2;
  localparam int ST_RUN_BIT     = 0;
  localparam int ST_REV_BIT     = 1;
  localparam int ST_LOCK_BIT    = 2;
  localparam int ST_EDIT_BIT    = 3;

  // Reset values
  localparam logic [1:0]  RST_TERM_MODE   = 2'h0;
  localparam logic [3:0]  RST_MAIN_SRC    = 4'h8;
  localparam logic [15:0] RST_DIGITAL_SET = 16'h1388;  // 50.00 Hz
  localparam logic [15:0] RST_MAX_FREQ    = 16'h1388;  // 50.00 Hz
  localparam logic [15:0] RST_FOLLOW_COEF = 16'h2710;  // 100.00 %
  localparam logic [15:0] RST_POT_VALUE   = 16'h0000;

  // Percent full scale: 100.00 % in units of 0.01 %
  localparam logic [15:0] PCT_FULL        = 16'h2710;

  // Pulse measurement: 100 MHz over a 10 ms gate; counts times 100
  // give Hz, range 0 .. 100.00 kHz
  localparam int CLK_HZ          = 100_000_000;
  localparam int GATE_MS         = 10;
  localparam int GATE_CYCLES     = CLK_HZ / 1000 * GATE_MS;
  localparam logic [19:0] GATE_LAST = 20'(GATE_CYCLES - 1);
  localparam logic [15:0] PULSE_FULL_COUNT = 16'h03E8; // 100 kHz

  // Potentiometer step per detent, 0.01 Hz units
  localparam logic [15:0] POT_STEP = 16'h000A;

  // Terminal control modes
  typedef enum logic [1:0] {
    TM_TWO_RUN_DIR = 2'h0,
    TM_TWO_FWD_REV = 2'h1,
    TM_THREE_FR    = 2'h2,
    TM_THREE_RUN   = 2'h3
  } term_mode_e;

  // Main source codes
  localparam logic [3:0] SRC_DIGITAL  = 4'h0;
  localparam logic [3:0] SRC_AIN_ONE  = 4'h1;
  localparam logic [3:0] SRC_AIN_TWO  = 4'h2;
  localparam logic [3:0] SRC_PULSE    = 4'h5;
  localparam logic [3:0] SRC_COMM_PCT = 4'h6;
  localparam logic [3:0] SRC_COMM_DIR = 4'h7;
  localparam logic [3:0] SRC_POT      = 4'h8;
  localparam logic [3:0] SRC_PRESET   = 4'hF;  // preset override code; a main source write of 4'hF selects it too

  // Field terminals, all raw asynchronous pins
  typedef struct packed {
    logic run;
    logic direction;
    logic stop_nc;      // normally closed stop contact, high when closed
    logic ext_stop;     // stop key or external stop command
    logic pulse;
    logic pot_cw;
    logic pot_ccw;
    logic pot_enter;
    logic pot_escape;
  } terminals_s;

  // Digital-input override functions
  typedef struct packed {
    logic [3:0] preset;  // preset-speed inputs 1..4
    logic       force_digital;
    logic       force_ain_one;
    logic       force_ain_two;
    logic       force_comm;
  } override_s;

  // Run command toward speed control
  typedef struct packed {
    logic run;
    logic reverse;
  } run_cmd_s;

endpackage
`default_nettype wire

// ===== field_panel.sv
// Field switches and pushbuttons in front of the drive terminals.
// Assumes the bench sets the switch levels just after mclk edges.
`timescale 1ns/1ps
`default_nettype none
module field_panel (
  input  wire logic                   [6:0] pb,
  output var  drive_front_pkg::terminals_s terminals
);
  // Stop contact is normally closed, so pressing it opens the line
  assign terminals.run        = pb[0];
  assign terminals.direction  = pb[1];
  assign terminals.stop_nc    = !pb[2];
  assign terminals.ext_stop   = pb[3];
  assign terminals.pulse      = 1'b0;
  assign terminals.pot_cw     = pb[4];
  assign terminals.pot_ccw    = 1'b0;
  assign terminals.pot_enter  = pb[5];
  assign terminals.pot_escape = pb[6];
endmodule // field_panel
`default_nettype wire

// ===== pulse_freq_meter.sv
// Gate-counting frequency meter for the pulse input pin.
// Assumes a synchronised pulse input on mclk; result as 0.01 % of
// the 100 kHz full scale.
`timescale 1ns/1ps
`default_nettype none
module pulse_freq_meter (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        pulse_sync,
  output logic      [15:0] pulse_percent
);

  logic [19:0] gate_count;
  logic [15:0] edge_count;
  logic        pulse_prev;

  wire         gate_end   = (gate_count == drive_front_pkg::GATE_LAST);
  wire         rise       = pulse_sync & ~pulse_prev;
  // Above 100 kHz the count saturates at full scale
  wire  [15:0] clamped    =
      (edge_count > drive_front_pkg::PULSE_FULL_COUNT) ?
      drive_front_pkg::PULSE_FULL_COUNT : edge_count;
  wire  [31:0] scaled     = 32'(clamped) * 32'(drive_front_pkg::PCT_FULL);
  wire  [31:0] percent_w  =
      scaled / 32'(drive_front_pkg::PULSE_FULL_COUNT);

  // Count rising edges inside a fixed gate, latch at gate end
  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_count    <= 20'h00000;
      edge_count    <= 16'h0000;
      pulse_prev    <= 1'b0;
      pulse_percent <= 16'h0000;
    end else begin
      pulse_prev <= pulse_sync;
      if (gate_end) begin
        gate_count    <= 20'h00000;
        edge_count    <= {15'h0000, rise};
        pulse_percent <= percent_w[15:0];
      end else begin
        gate_count <= gate_count + 20'h00001;
        if (rise && edge_count != 16'hFFFF) begin
          edge_count <= edge_count + 16'h0001;
        end
      end
    end
  end

endmodule // pulse_freq_meter
`default_nettype wire

// ===== test_run_command_and_main_freq_select.sv
// Self-checking bench for the drive front end.
// Assumes the package, the field panel model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_run_command_and_main_freq_select;
  logic                       mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]                 avs_address;
  logic [31:0]                avs_writedata, avs_readdata, q;
  logic [6:0]                 pb;
  logic signed [15:0]         ain_one, ain_two;
  logic signed [16:0]         main_ref;
  drive_front_pkg::terminals_s terminals;
  drive_front_pkg::override_s  overrides;
  drive_front_pkg::run_cmd_s   run_cmd;
  int                         n_fail = 0, n_checks = 0;
  logic [16:0] ovr_exp [5] = '{17'h1EC78, 17'h003E8, 17'h009C4,
                               17'h01388, 17'h004D2};

  field_panel i_field_panel (.pb(pb), .terminals(terminals));
  drive_front i_drive_front (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .terminals(terminals),
    .overrides(overrides), .analog_in_one(ain_one),
    .analog_in_two(ain_two), .preset_freq(16'h04D2),
    .run_cmd(run_cmd), .main_ref(main_ref));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One bus cycle; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) n_fail++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string s, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask

  // Settling margins cover the two-stage synchronisers
  task automatic mr(input logic [16:0] e);
    tick(6);
    chk("main_ref", {15'h0, e}, {15'h0, main_ref});
  endtask

  task automatic rc(input logic [1:0] e);
    tick(6);
    chk("run_cmd", {30'h0, e}, {30'h0, run_cmd});
  endtask

  task automatic pulse(input int k);
    pb[k] <= 1'b1;
    tick(6);
    pb[k] <= 1'b0;
  endtask

  // Cuts a hang short well past the expected run length
  initial begin
    #50000;
    n_fail++;
    finish_test;
  end

  // Register, source selection and terminal scenarios
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    pb = 7'h00;
    overrides = '0;
    ain_one = 16'sh1388;
    ain_two = 16'sh07D0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    rd("main_src", drive_front_pkg::OFF_MAIN_SRC, 32'h8);
    mr(17'h00000);
    rd("unmapped", 6'h3C, 32'h0);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h0);
    mr(17'h01388);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h1);
    mr(17'h009C4);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h2);
    mr(17'h003E8);
    wr(drive_front_pkg::OFF_COMM_PERCENT, 32'h0000D8F0);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h6);
    mr(17'h1EC78);
    wr(drive_front_pkg::OFF_COMM_DIRECT, 32'h00001B58);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h7);
    mr(17'h01388);
    wr(drive_front_pkg::OFF_COMM_FOLLOW, 32'h1388);
    wr(drive_front_pkg::OFF_FOLLOW_COEF, 32'h1388);
    wr(drive_front_pkg::OFF_LINK_CFG, 32'h1);
    mr(17'h004E2);
    wr(drive_front_pkg::OFF_LINK_CFG, 32'h0);
    // Overrides stacked from lowest to highest priority
    for (int i = 0; i < 5; i++) begin
      overrides <= overrides | 8'(1 << i);
      mr(ovr_exp[i]);
    end
    overrides <= '0;
    mr(17'h01388);
    // Reserved code holds the last reference; idle pulse pin reads zero
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h3);
    mr(17'h01388);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h5);
    mr(17'h00000);
    wr(drive_front_pkg::OFF_MAIN_SRC, 32'h8);
    pulse(4);
    mr(17'h0000A);
    pulse(6);
    mr(17'h00000);
    pulse(4);
    pulse(5);
    rd("pot_view", drive_front_pkg::OFF_POT_VIEW, 32'hA);
    pb[0] <= 1'b1;
    rc(2'b10);
    pb[1] <= 1'b1;
    rc(2'b11);
    wr(drive_front_pkg::OFF_LINK_CFG, 32'h4);
    rc(2'b10);
    wr(drive_front_pkg::OFF_LINK_CFG, 32'h0);
    pulse(3);
    // A stopped drive still shows the direction level in mode 0
    rc(2'b01);
    pb[0] <= 1'b0;
    tick(6);
    pb[0] <= 1'b1;
    rc(2'b11);
    wr(drive_front_pkg::OFF_TERM_MODE, 32'h1);
    rc(2'b00);
    pb[0] <= 1'b0;
    rc(2'b11);
    pb[1] <= 1'b0;
    wr(drive_front_pkg::OFF_TERM_MODE, 32'h2);
    pulse(0);
    rc(2'b10);
    pulse(1);
    rc(2'b11);
    // Stop keeps the last direction; closing the contact must not restart
    pb[2] <= 1'b1;
    rc(2'b01);
    pb[2] <= 1'b0;
    rc(2'b01);
    wr(drive_front_pkg::OFF_TERM_MODE, 32'h3);
    pb[1] <= 1'b1;
    pulse(0);
    rc(2'b11);
    pb[2] <= 1'b1;
    rc(2'b01);
    finish_test;
  end
endmodule // test_run_command_and_main_freq_select
`default_nettype wire
